// File: design/stp_pkg.sv
package stp_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int OFF_DEF_NS = 30000;
    localparam int OFF_RES_NS = 30000;
    localparam int SENSE_MASK_NS = 1000;
    localparam int CROSSOVER_GAP_NS = 475;
    localparam int FAST_NUM = 5;
    localparam int FAST_DEN = 16;
    localparam int OFF_DEF_CYC = (OFF_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_RES_CYC = (OFF_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SENSE_MASK_CYC = (SENSE_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = (CROSSOVER_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 10;
    localparam logic [2:0] HOME_POS = 3'h1;
    localparam logic [15:0] MAG_PH1 = 16'h4646;
    localparam logic [15:0] MAG_PH2 = 16'h6464;
    localparam logic [7:0] POS_PH1 = 8'h83;
    localparam logic [7:0] POS_PH2 = 8'h0E;
    localparam logic [3:0] GATE_OFF = 4'h0;
    localparam logic [3:0] GATE_FWD = 4'h9;
    localparam logic [3:0] GATE_REV = 4'h6;
    localparam logic [3:0] GATE_SLOW = 4'h5;
    localparam int SYNC_W = 11;
    localparam int SI_STEP = 0;
    localparam int SI_DIR = 1;
    localparam int SI_RES = 2;
    localparam int SI_RSTN = 3;
    localparam int SI_EN = 4;
    localparam int SI_TSET = 5;
    localparam int SI_HOT = 6;
    localparam int SI_COOL = 7;
    localparam int SI_UV = 8;
    localparam int SI_SENSE = 9;
endpackage

// File: design/stp_phase_if.sv
`timescale 1ns/100ps
interface stp_phase_if;
    logic                run;
    logic                positive;
    logic                mixed;
    logic                sense_trip;
    logic [stp_pkg::CNT_W-1:0] off_cycles;
    logic [3:0]          gates;
    modport ctrl (output run, positive, mixed, sense_trip, off_cycles, input gates);
    modport chop (input run, positive, mixed, sense_trip, off_cycles, output gates);
endinterface

// File: design/stp_sync.sv
`timescale 1ns/100ps
module stp_sync (
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    input  wire logic [stp_pkg::SYNC_W-1:0] d_in,
    output logic      [stp_pkg::SYNC_W-1:0] q_out,
    output logic      [stp_pkg::SYNC_W-1:0] rise_out
);
    import stp_pkg::*;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic [SYNC_W-1:0] last_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    always_comb begin
        q_out    = sync_reg;
        rise_out = sync_reg & ~last_reg;
    end
endmodule

// File: design/stp_chopper.sv
`timescale 1ns/100ps
module stp_chopper (
    input  wire logic clk_in,
    input  wire logic rst_in,
    stp_phase_if.chop ph
);
    import stp_pkg::*;
    typedef enum logic [1:0] {CH_IDLE, CH_DRIVE, CH_DECAY} stp_chop_type;
    stp_chop_type     state_reg, state_next;
    logic [CNT_W-1:0] off_reg, off_next;
    logic [CNT_W-1:0] mask_reg, mask_next;
    logic [CNT_W-1:0] gap_reg, gap_next;
    logic [3:0]       gates_reg, gates_next;
    logic [3:0]       drive_pat;
    logic [3:0]       target;
    logic [CNT_W-1:0] fast_left;

    always_comb begin
        drive_pat  = ph.positive ? GATE_FWD : GATE_REV;
        fast_left  = CNT_W'((32'(ph.off_cycles) * FAST_NUM) / FAST_DEN);
        state_next = state_reg;
        off_next   = off_reg;
        mask_next  = (mask_reg != '0) ? mask_reg - 1'b1 : mask_reg;
        gap_next   = (gap_reg != '0) ? gap_reg - 1'b1 : gap_reg;
        target     = GATE_OFF;
        case (state_reg)
            CH_IDLE: begin
                if (ph.run) begin
                    state_next = CH_DRIVE;
                end
            end
            CH_DRIVE: begin
                target = drive_pat;
                // trips during the mask window are switching noise
                if (ph.sense_trip && gates_reg == drive_pat && mask_reg == '0) begin
                    state_next = CH_DECAY;
                    off_next   = ph.off_cycles - 1'b1;
                end
            end
            CH_DECAY: begin
                // fast part reverses the diagonal, slow part shorts via both low sides
                if (ph.mixed && (ph.off_cycles - off_reg) <= fast_left) begin
                    target = drive_pat ^ 4'hF;
                end else begin
                    target = GATE_SLOW;
                end
                if (off_reg == '0) begin
                    state_next = CH_DRIVE;
                end else begin
                    off_next = off_reg - 1'b1;
                end
            end
            default: begin
                state_next = CH_IDLE;
            end
        endcase
        if (!ph.run) begin
            state_next = CH_IDLE;
            target     = GATE_OFF;
        end
        gates_next = gates_reg;
        if (target != gates_reg) begin
            if (gates_reg != GATE_OFF || target == GATE_OFF) begin
                gates_next = GATE_OFF;
                gap_next   = CNT_W'(GAP_CYC);
            end else if (gap_reg == '0) begin
                gates_next = target;
                mask_next  = CNT_W'(SENSE_MASK_CYC);
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= CH_IDLE;
            off_reg   <= '0;
            mask_reg  <= '0;
            gap_reg   <= CNT_W'(GAP_CYC);
            gates_reg <= GATE_OFF;
        end else begin
            state_reg <= state_next;
            off_reg   <= off_next;
            mask_reg  <= mask_next;
            gap_reg   <= gap_next;
            gates_reg <= gates_next;
        end
    end

    assign ph.gates = gates_reg;
endmodule

// File: design/stp_translator_top.sv
`timescale 1ns/100ps
module stp_translator_top (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       step_in,
    input  wire logic       dir_in,
    input  wire logic       resolution_select_in,
    input  wire logic       reset_n_in,
    input  wire logic       enable_n_in,
    input  wire logic       off_time_timing_set_in,
    input  wire logic       over_temp_in,
    input  wire logic       temp_cooled_in,
    input  wire logic       uvlo_in,
    input  wire logic [1:0] sense_trip_in,
    output logic      [7:0] gate_out,
    output logic      [2:0] position_out,
    output logic      [1:0] decay_mixed_out,
    output logic            outputs_on_out,
    output logic            fault_out
);
    import stp_pkg::*;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] sync_rise;
    logic [2:0]        pos_reg, pos_next;
    logic [1:0]        mixed_reg, mixed_next;
    logic              hot_reg, hot_next;
    logic              allow_reg, allow_next;
    logic              fault_reg, fault_next;
    logic [7:0]        gate_reg, gate_next;
    logic [CNT_W-1:0]  off_cyc_reg, off_cyc_next;
    logic              hold_home;
    logic [2:0]        step_pos;
    logic [3:0]        gates_w [2];

    stp_phase_if ph_if [2] ();

    stp_sync u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .d_in     ({sense_trip_in, uvlo_in, temp_cooled_in, over_temp_in,
                    off_time_timing_set_in, enable_n_in, reset_n_in,
                    resolution_select_in, dir_in, step_in}),
        .q_out    (sync_q),
        .rise_out (sync_rise)
    );

    function automatic logic [1:0] mag_of(input logic [15:0] tbl, input logic [2:0] idx);
        mag_of = tbl[{idx, 1'b0} +: 2];
    endfunction

    always_comb begin
        // translator home is held by the pin, the undervoltage lockout and reset alike
        hold_home = !sync_q[SI_RSTN] || sync_q[SI_UV];
        step_pos  = pos_reg;
        if (sync_q[SI_RES]) begin
            step_pos = sync_q[SI_DIR] ? pos_reg + 3'h1 : pos_reg - 3'h1;
        end else if (pos_reg[0]) begin
            step_pos = sync_q[SI_DIR] ? pos_reg + 3'h2 : pos_reg - 3'h2;
        end else begin
            // from a half-step point, full step lands on the nearest two-phase point
            step_pos = sync_q[SI_DIR] ? pos_reg + 3'h1 : pos_reg - 3'h1;
        end
        pos_next   = pos_reg;
        mixed_next = mixed_reg;
        if (hold_home) begin
            pos_next   = HOME_POS;
            mixed_next = 2'b11;
        end else if (sync_rise[SI_STEP]) begin
            pos_next = step_pos;
            // equal magnitude counts as rising: only a strict drop gives mixed
            mixed_next[0] = mag_of(MAG_PH1, step_pos) < mag_of(MAG_PH1, pos_reg);
            mixed_next[1] = mag_of(MAG_PH2, step_pos) < mag_of(MAG_PH2, pos_reg);
        end
        hot_next = hot_reg;
        if (sync_q[SI_HOT]) begin
            hot_next = 1'b1;
        end else if (sync_q[SI_COOL]) begin
            hot_next = 1'b0;
        end
        allow_next   = !hold_home && !sync_q[SI_EN] && !hot_reg;
        fault_next   = hot_reg || sync_q[SI_UV];
        off_cyc_next = sync_q[SI_TSET] ? CNT_W'(OFF_DEF_CYC) : CNT_W'(OFF_RES_CYC);
        gate_next    = {gates_w[1], gates_w[0]};
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_reg     <= HOME_POS;
            mixed_reg   <= 2'b11;
            hot_reg     <= 1'b0;
            allow_reg   <= 1'b0;
            fault_reg   <= 1'b0;
            gate_reg    <= 8'h00;
            off_cyc_reg <= CNT_W'(OFF_DEF_CYC);
        end else begin
            pos_reg     <= pos_next;
            mixed_reg   <= mixed_next;
            hot_reg     <= hot_next;
            allow_reg   <= allow_next;
            fault_reg   <= fault_next;
            gate_reg    <= gate_next;
            off_cyc_reg <= off_cyc_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_phase
            logic [15:0] mag_tbl;
            logic [7:0]  pol_tbl;
            assign mag_tbl = (g == 0) ? MAG_PH1 : MAG_PH2;
            assign pol_tbl = (g == 0) ? POS_PH1 : POS_PH2;
            // zero target current leaves the bridge fully off
            assign ph_if[g].run        = allow_reg && (mag_of(mag_tbl, pos_reg) != 2'b00);
            assign ph_if[g].positive   = pol_tbl[pos_reg];
            assign ph_if[g].mixed      = mixed_reg[g];
            assign ph_if[g].sense_trip = sync_q[SI_SENSE+g];
            assign ph_if[g].off_cycles = off_cyc_reg;
            assign gates_w[g]          = ph_if[g].gates;
            stp_chopper u_chop (
                .clk_in (clk_in),
                .rst_in (rst_in),
                .ph     (ph_if[g])
            );
        end
    endgenerate

    // one extra register stage on the gates keeps top outputs flopped
    assign gate_out        = gate_reg;
    assign position_out    = pos_reg;
    assign decay_mixed_out = mixed_reg;
    assign outputs_on_out  = allow_reg;
    assign fault_out       = fault_reg;
endmodule

// File: tb/stp_ctl_model.sv
`timescale 1ns/100ps
module stp_ctl_model (
    input  wire logic clk_in,
    output logic      step_out,
    output logic      dir_out,
    output logic      res_out
);
    initial begin
        step_out = 1'b0;
        dir_out = 1'b0;
        res_out = 1'b0;
    end
    // levels move 1 us ahead of the edge, well past the setup need
    task automatic send(input logic d, input logic r);
        dir_out = d;
        res_out = r;
        repeat (25) @(negedge clk_in);
        step_out = 1'b1;
        repeat (25) @(negedge clk_in);
        step_out = 1'b0;
        repeat (25) @(negedge clk_in);
    endtask
endmodule

// File: tb/stp_translator_monitor.sv
`timescale 1ns/100ps
module stp_translator_monitor (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       step_in,
    input wire logic       reset_n_in,
    input wire logic       enable_n_in,
    input wire logic       temp_cooled_in,
    input wire logic       uvlo_in,
    input wire logic [7:0] gate_out,
    input wire logic [2:0] position_out,
    input wire logic [1:0] decay_mixed_out,
    input wire logic       outputs_on_out,
    input wire logic       fault_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // 2 full, 1 about 70 percent, 0 off
    function automatic logic [1:0] mag(input logic [2:0] p, input logic ph);
        return p[0] ? 2'h1 : ((p[1] ^ ph) ? 2'h0 : 2'h2);
    endfunction
    sequence s_quiet;
        !step_in [*6];
    endsequence
    sequence s_gap;
        (gate_out[3:0] == 4'h0) [*8];
    endsequence
    AST_HOME: assert property (!reset_n_in [*5] |-> position_out == 3'h1 && !outputs_on_out)
        else $error("home not held");
    AST_ENABLE: assert property (enable_n_in [*5] |-> !outputs_on_out)
        else $error("outputs on while disabled");
    AST_UVLO: assert property (uvlo_in [*5] |-> fault_out && position_out == 3'h1)
        else $error("undervoltage not locked out");
    AST_LATCH: assert property ((!temp_cooled_in && !uvlo_in) [*5] ##0 fault_out |=> fault_out)
        else $error("thermal fault released early");
    AST_QUIET: assert property (s_quiet |-> $stable(position_out) || position_out == 3'h1)
        else $error("position moved without a step");
    AST_MOVE: assert property ($changed(position_out) && position_out != 3'h1 |->
        3'(position_out - $past(position_out)) inside {3'h1, 3'h2, 3'h6, 3'h7}) else $error("bad move");
    AST_DECAY: assert property ($changed(position_out) && reset_n_in && !uvlo_in &&
        $past(reset_n_in, 4) && !$past(uvlo_in, 4) |-> decay_mixed_out ==
        {mag(position_out, 1'b1) < mag($past(position_out), 1'b1),
         mag(position_out, 1'b0) < mag($past(position_out), 1'b0)}) else $error("decay choice wrong");
    AST_OFF: assert property (!outputs_on_out [*5] |-> gate_out == 8'h00)
        else $error("gates on while outputs off");
    AST_GAP: assert property ($changed(gate_out[3:0]) && gate_out[3:0] != 4'h0 |->
        $past(gate_out[3:0]) == 4'h0) else $error("leg swapped without gap");
    AST_GAPLEN: assert property ($fell(|gate_out[3:0]) |-> s_gap)
        else $error("gap too short");
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic       clk_in, rst_in, step, dir, res, pin_reset_n, enable_n, hot, cool, uv, on, flt;
    logic [1:0] trip, mix;
    logic [7:0] gate;
    logic [2:0] pos, ep;
    int         num_errors, checks_done, cycles;
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    stp_translator_top u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .step_in(step), .dir_in(dir),
        .resolution_select_in(res), .reset_n_in(pin_reset_n), .enable_n_in(enable_n),
        .off_time_timing_set_in(1'b1), .over_temp_in(hot), .temp_cooled_in(cool),
        .uvlo_in(uv), .sense_trip_in(trip), .gate_out(gate), .position_out(pos),
        .decay_mixed_out(mix), .outputs_on_out(on), .fault_out(flt));
    stp_ctl_model u_ctl (.clk_in(clk_in), .step_out(step), .dir_out(dir), .res_out(res));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    function automatic logic [1:0] mag(input logic [2:0] p, input logic ph);
        return p[0] ? 2'h1 : ((p[1] ^ ph) ? 2'h0 : 2'h2);
    endfunction
    task automatic t_steps(input int n, input logic d, input logic r);
        logic [2:0] old;
        repeat (n) begin
            old = ep;
            ep = (r || !ep[0]) ? (d ? ep + 3'h1 : ep - 3'h1) : (d ? ep + 3'h2 : ep - 3'h2);
            u_ctl.send(d, r);
            check("position", {5'h0, pos}, {5'h0, ep});
            check("decay", {6'h0, mix}, {6'h0, mag(ep, 1'b1) < mag(old, 1'b1),
                mag(ep, 1'b0) < mag(old, 1'b0)});
        end
    endtask
    // phase 1 falls 100 to 70 (mixed), phase 2 rises 0 to 70 (slow)
    task automatic t_chop();
        t_steps(1, 1'b1, 1'b1);
        w(100);
        check("drive", gate, 8'h99);
        trip = 2'h3;
        w(5);
        trip = 2'h0;
        w(95);
        check("fast", gate, 8'h56);
        w(300);
        check("slow", gate, 8'h55);
        w(500);
        check("resume", gate, 8'h99);
    endtask
    task automatic t_enable();
        enable_n = 1'b1;
        w(10);
        check("disabled", {on, gate[6:0]}, 8'h00);
        t_steps(1, 1'b1, 1'b1);
        enable_n = 1'b0;
        w(10);
    endtask
    task automatic t_pin_reset();
        pin_reset_n = 1'b0;
        w(6);
        u_ctl.send(1'b1, 1'b1);
        check("home", {3'h0, on, mix, pos}, 8'h19);
        ep = 3'h1;
        pin_reset_n = 1'b1;
        w(6);
    endtask
    task automatic t_fault();
        hot = 1'b1;
        w(6);
        hot = 1'b0;
        w(6);
        check("thermal", {6'h0, flt, on}, 8'h02);
        cool = 1'b1;
        w(6);
        cool = 1'b0;
        w(6);
        check("cooled", {6'h0, flt, on}, 8'h01);
        t_steps(1, 1'b1, 1'b1);
        uv = 1'b1;
        w(6);
        check("uvlo", {3'h0, flt, on, pos}, 8'h11);
        ep = 3'h1;
        uv = 1'b0;
        w(6);
        check("restart", {3'h0, flt, on, pos}, 8'h09);
    endtask
    initial begin
        rst_in = 1'b1;
        pin_reset_n = 1'b1;
        {enable_n, hot, cool, uv, trip} = 6'h00;
        {num_errors, checks_done, cycles} = '0;
        ep = 3'h1;
        w(8);
        rst_in = 1'b0;
        w(6);
        check("start", {2'h0, flt, on, mix, pos}, 8'h39);
        t_steps(4, 1'b1, 1'b0);
        t_steps(1, 1'b0, 1'b1);
        t_chop();
        t_steps(8, 1'b1, 1'b1);
        t_steps(3, 1'b0, 1'b0);
        t_steps(1, 1'b0, 1'b1);
        t_steps(1, 1'b1, 1'b0);
        t_enable();
        t_pin_reset();
        t_fault();
        report_and_stop();
    end
    // whole run is near 2700 cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            num_errors++;
            report_and_stop();
        end
    end
endmodule
bind stp_translator_top stp_translator_monitor u_mon (
    .clk_in(clk_in), .rst_in(rst_in), .step_in(step_in), .reset_n_in(reset_n_in),
    .enable_n_in(enable_n_in), .temp_cooled_in(temp_cooled_in), .uvlo_in(uvlo_in),
    .gate_out(gate_out), .position_out(position_out), .decay_mixed_out(decay_mixed_out),
    .outputs_on_out(outputs_on_out), .fault_out(fault_out));
